// file: rtl/sfdp_reader.sv
// Notes on behaviour
// (R1) command 5Ah reads a separate parameter space, not the main array
// (R2) the header starts at byte zero, the entry point of the read
// (R3) parameter tables start at 0300h; gaps after the header read undefined
// (R4) the space is read-only; any other command is ignored
// (R5) bytes 00h..02h read 53h, 46h, 44h
// (R6) layout is header, then basic table, then four-byte instruction table
// (R7) the host locates tables only through header pointers
// (R8) header holds revision and pointer for each parameter table
// (R9) byte 05h reads major revision 01h, byte 04h minor revision 06h
// (R10) byte 06h holds zero-based header count 01h, two tables
// (R11) opcode, 24-bit address, 8 dummy clocks, MSB-first bytes, address advances
`timescale 1ns/1ps
module sfdp_reader #(
  parameter logic [sfdp_pkg::BASIC_LEN*8-1:0] BASIC_TABLE = {sfdp_pkg::BASIC_LEN{8'hFF}},
  parameter logic [sfdp_pkg::FOURB_LEN*8-1:0] FOURB_TABLE = {sfdp_pkg::FOURB_LEN{8'hFF}}
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  output logic fill_active
);
  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_DATA,
    ST_IGNORE
  } link_state_t;

  // link side state (serial clock domain)
  link_state_t state;
  link_state_t next_state;
  logic [sfdp_pkg::CNT_BITS-1:0] bit_cnt;
  logic [sfdp_pkg::CNT_BITS-1:0] next_bit_cnt;
  logic [sfdp_pkg::CMD_BITS-1:0] cmd_shift;
  logic [sfdp_pkg::ADDR_BITS-1:0] addr_shift;
  logic req;
  logic [2:0] out_cnt;
  logic [sfdp_pkg::BYTE_BITS-1:0] out_shift;
  logic link_rst;
  logic sck_n;

  // fill side state (system clock domain)
  logic req_m;
  logic req_s;
  logic flush;
  logic [sfdp_pkg::ADDR_BITS-1:0] fill_addr;
  logic fifo_wr_rst;

  // decode wires
  logic [sfdp_pkg::CMD_BITS-1:0] cmd_word;
  logic cmd_last;
  logic addr_last;
  logic dummy_last;
  logic cmd_is_read;
  logic byte_start;
  logic [sfdp_pkg::BYTE_BITS-1:0] head_byte;

  sfdp_stream_if #(.WIDTH(sfdp_pkg::FIFO_WIDTH)) stream ();

  // byte at a parameter-space location
  function automatic logic [7:0] param_byte(input logic [23:0] a);
    logic [23:0] off;
    off = '0;
    if (a < 24'(sfdp_pkg::HDR_LEN)) begin
      return sfdp_pkg::HEADER[a[4:0]]; // R2 R5 R8 R9 R10
    end
    if (a >= sfdp_pkg::BASIC_TABLE_BASE &&
        a < sfdp_pkg::BASIC_TABLE_BASE + 24'(sfdp_pkg::BASIC_LEN)) begin
      off = a - sfdp_pkg::BASIC_TABLE_BASE; // R3 R6
      return BASIC_TABLE[(sfdp_pkg::BASIC_LEN - 1 - int'(off)) * 8 +: 8];
    end
    if (a >= sfdp_pkg::FOURB_TABLE_BASE &&
        a < sfdp_pkg::FOURB_TABLE_BASE + 24'(sfdp_pkg::FOURB_LEN)) begin
      off = a - sfdp_pkg::FOURB_TABLE_BASE; // R6
      return FOURB_TABLE[(sfdp_pkg::FOURB_LEN - 1 - int'(off)) * 8 +: 8];
    end
    return sfdp_pkg::FILL_BYTE; // R3
  endfunction

  // a frame ends, and the link logic clears, whenever chip select is high
  assign link_rst = rst || cs_n;
  assign sck_n = ~sck;

  // decode of the serial sequence
  assign cmd_word = {cmd_shift[sfdp_pkg::CMD_BITS-2:0], si};
  assign cmd_last = (bit_cnt == sfdp_pkg::CNT_BITS'(sfdp_pkg::CMD_BITS - 1));
  assign addr_last = (bit_cnt == sfdp_pkg::CNT_BITS'(sfdp_pkg::ADDR_BITS - 1));
  assign dummy_last = (bit_cnt == sfdp_pkg::CNT_BITS'(sfdp_pkg::DUMMY_CLKS - 1));
  assign cmd_is_read = (cmd_word == sfdp_pkg::CMD_READ_PARAMS); // R1
  assign byte_start = (state == ST_DATA) && (out_cnt == 3'h0);

  // next state of the input sequencer
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt + sfdp_pkg::CNT_BITS'(1);
    unique case (state)
      ST_CMD: begin
        if (cmd_last) begin
          next_bit_cnt = '0;
          // anything but the parameter read, program or erase included, is dropped
          next_state = cmd_is_read ? ST_ADDR : ST_IGNORE; // R4
        end
      end
      ST_ADDR: begin
        if (addr_last) begin
          next_bit_cnt = '0;
          next_state = ST_DUMMY; // R11
        end
      end
      ST_DUMMY: begin
        if (dummy_last) begin
          next_bit_cnt = '0;
          next_state = ST_DATA; // R11
        end
      end
      ST_DATA: begin
        next_bit_cnt = '0;
      end
      ST_IGNORE: begin
        next_bit_cnt = '0;
      end
    endcase
  end

  // input sequencer, sampling on the rising serial clock
  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      state <= ST_CMD;
      bit_cnt <= '0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
    end
  end

  // opcode and address shifters, MSB first
  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      cmd_shift <= '0;
      addr_shift <= '0;
    end else begin
      if (state == ST_CMD) begin
        cmd_shift <= cmd_word;
      end
      if (state == ST_ADDR) begin
        addr_shift <= {addr_shift[sfdp_pkg::ADDR_BITS-2:0], si}; // R11
      end
    end
  end

  // request level, raised once the address is complete, held to frame end
  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      req <= 1'b0;
    end else if (state == ST_ADDR && addr_last) begin
      req <= 1'b1; // R1
    end
  end

  // bit counter of the outgoing byte, on the falling serial clock
  always_ff @(posedge sck_n or posedge link_rst) begin
    if (link_rst) begin
      out_cnt <= '0;
    end else if (state == ST_DATA) begin
      out_cnt <= out_cnt + 3'h1;
    end
  end

  // next byte from the buffer, or the fill value if it ran dry
  assign head_byte = stream.rd_valid ? stream.rd_data : sfdp_pkg::FILL_BYTE;
  assign stream.rd_ready = byte_start;

  // output shifter, MSB first on the falling edge
  always_ff @(posedge sck_n or posedge link_rst) begin
    if (link_rst) begin
      out_shift <= '0;
      so <= 1'b0;
      so_oe <= 1'b0;
    end else if (state == ST_DATA) begin
      so_oe <= 1'b1;
      if (byte_start) begin
        so <= head_byte[sfdp_pkg::BYTE_BITS-1]; // R11
        out_shift <= {head_byte[sfdp_pkg::BYTE_BITS-2:0], 1'b0};
      end else begin
        so <= out_shift[sfdp_pkg::BYTE_BITS-1]; // R11
        out_shift <= {out_shift[sfdp_pkg::BYTE_BITS-2:0], 1'b0};
      end
    end
  end

  // request level into the system clock domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_m <= 1'b0;
      req_s <= 1'b0;
    end else begin
      req_m <= req;
      req_s <= req_m;
    end
  end

  // buffer write side is held clear between frames
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flush <= 1'b1;
    end else begin
      flush <= !req_s;
    end
  end

  assign fifo_wr_rst = rst || flush;

  // fill engine: loads the start address, then walks the space upward
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fill_active <= 1'b0;
      fill_addr <= '0;
    end else if (!req_s) begin
      fill_active <= 1'b0;
    end else if (!fill_active) begin
      fill_active <= 1'b1;
      fill_addr <= addr_shift; // R2
    end else if (stream.wr_ready) begin
      fill_addr <= fill_addr + 24'h000001; // R11
    end
  end

  // the space is a constant table, so nothing can write into it
  assign stream.wr_valid = fill_active && !flush;
  assign stream.wr_data = param_byte(fill_addr); // R1 R4

  // byte buffer between the two clock domains
  sfdp_fifo #(
    .WIDTH(sfdp_pkg::FIFO_WIDTH),
    .DEPTH(sfdp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .wr_clk(clk),
    .wr_rst(fifo_wr_rst),
    .rd_clk(sck_n),
    .rd_rst(link_rst),
    .st(stream.fifo)
  );
endmodule

// file: rtl/sfdp_pkg.sv
package sfdp_pkg;
  // serial framing
  localparam logic [7:0] CMD_READ_PARAMS = 8'h5A;
  localparam int CMD_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int DUMMY_CLKS = 8;
  localparam int BYTE_BITS = 8;
  localparam int CNT_BITS = 5;
  // buffer between the fill engine and the link
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  // parameter space layout
  localparam logic [23:0] HDR_BASE = 24'h000000;
  localparam int HDR_LEN = 24;
  localparam logic [23:0] BASIC_TABLE_BASE = 24'h000300;
  localparam logic [7:0] BASIC_DWORDS = 8'h10;
  localparam int BASIC_LEN = 64;
  localparam logic [23:0] FOURB_TABLE_BASE = 24'h000340;
  localparam logic [7:0] FOURB_DWORDS = 8'h02;
  localparam int FOURB_LEN = 8;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  // header bytes
  localparam logic [7:0] SIG_S = 8'h53;
  localparam logic [7:0] SIG_F = 8'h46;
  localparam logic [7:0] SIG_D = 8'h44;
  localparam logic [7:0] SIG_P = 8'h50;
  localparam logic [7:0] REV_MINOR = 8'h06;
  localparam logic [7:0] REV_MAJOR = 8'h01;
  localparam logic [7:0] NUM_PHDR = 8'h01;
  localparam logic [7:0] BASIC_ID = 8'h00;
  localparam logic [7:0] FOURB_ID = 8'h84;
  localparam logic [7:0] FOURB_MINOR = 8'h00;
  localparam logic [7:0] FOURB_MAJOR = 8'h01;
  localparam logic [7:0] HEADER [0:HDR_LEN-1] = '{
    SIG_S, SIG_F, SIG_D, SIG_P, REV_MINOR, REV_MAJOR, NUM_PHDR, FILL_BYTE,
    BASIC_ID, REV_MINOR, REV_MAJOR, BASIC_DWORDS,
    BASIC_TABLE_BASE[7:0], BASIC_TABLE_BASE[15:8], BASIC_TABLE_BASE[23:16], FILL_BYTE,
    FOURB_ID, FOURB_MINOR, FOURB_MAJOR, FOURB_DWORDS,
    FOURB_TABLE_BASE[7:0], FOURB_TABLE_BASE[15:8], FOURB_TABLE_BASE[23:16], FILL_BYTE
  };
endpackage

// file: rtl/sfdp_stream_if.sv
`timescale 1ns/1ps
interface sfdp_stream_if #(parameter int WIDTH = 8);
  logic wr_valid;
  logic wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [WIDTH-1:0] rd_data;
  modport user (output wr_valid, output wr_data, input wr_ready,
                input rd_valid, input rd_data, output rd_ready);
  modport fifo (input wr_valid, input wr_data, output wr_ready,
                output rd_valid, output rd_data, input rd_ready);
endinterface

// file: rtl/sfdp_fifo.sv
`timescale 1ns/1ps
module sfdp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic wr_clk,
  input wire logic wr_rst,
  input wire logic rd_clk,
  input wire logic rd_rst,
  sfdp_stream_if.fifo st
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wr_bin;
  logic [AW:0] wr_gray;
  logic [AW:0] rd_bin;
  logic [AW:0] rd_gray;
  logic [AW:0] rd_gray_m;
  logic [AW:0] rd_gray_s;
  logic [AW:0] wr_gray_m;
  logic [AW:0] wr_gray_s;
  logic full;
  logic empty;
  logic do_write;
  logic do_read;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // flags from the pointers seen across the crossing
  assign full = (wr_gray == {~rd_gray_s[AW:AW-1], rd_gray_s[AW-2:0]});
  assign empty = (rd_gray == wr_gray_s);
  assign do_write = st.wr_valid && !full;
  assign do_read = st.rd_ready && !empty;
  assign st.wr_ready = !full;
  assign st.rd_valid = !empty;
  assign st.rd_data = mem[rd_bin[AW-1:0]];

  // storage, written before the pointer that publishes it
  always_ff @(posedge wr_clk) begin
    if (do_write) begin
      mem[wr_bin[AW-1:0]] <= st.wr_data;
    end
  end

  // write pointer and read pointer synchroniser
  always_ff @(posedge wr_clk or posedge wr_rst) begin
    if (wr_rst) begin
      wr_bin <= '0;
      wr_gray <= '0;
      rd_gray_m <= '0;
      rd_gray_s <= '0;
    end else begin
      wr_bin <= wr_bin + (AW+1)'(do_write);
      wr_gray <= to_gray(wr_bin + (AW+1)'(do_write));
      rd_gray_m <= rd_gray;
      rd_gray_s <= rd_gray_m;
    end
  end

  // read pointer and write pointer synchroniser
  always_ff @(posedge rd_clk or posedge rd_rst) begin
    if (rd_rst) begin
      rd_bin <= '0;
      rd_gray <= '0;
      wr_gray_m <= '0;
      wr_gray_s <= '0;
    end else begin
      rd_bin <= rd_bin + (AW+1)'(do_read);
      rd_gray <= to_gray(rd_bin + (AW+1)'(do_read));
      wr_gray_m <= wr_gray;
      wr_gray_s <= wr_gray_m;
    end
  end
endmodule

// file: tb/sfdp_reader_properties.sv
`timescale 1ns/1ps
module sfdp_reader_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe,
  input wire logic fill_active
);
  logic [7:0] cnt;
  logic [31:0] head;
  // opcode match and the three signature bytes, first byte on top
  wire op_ok = head[31:24] == sfdp_pkg::CMD_READ_PARAMS;
  wire [23:0] sig = {sfdp_pkg::SIG_S, sfdp_pkg::SIG_F, sfdp_pkg::SIG_D};
  // counts serial edges of the frame, keeps opcode and address
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      cnt <= 8'h00;
      head <= 32'h0;
    end else begin
      if (cnt != 8'hFF) cnt <= cnt + 8'h01;
      if (cnt < 8'h20) head <= {head[30:0], si};
    end
  end
  // output pin quiet outside frames and on the first clock after reset is released
  a_oe_idle: assert property (@(posedge clk) disable iff (rst) cs_n |-> !so_oe)
    else $error("output enable high while deselected");
  a_so_quiet: assert property (@(posedge clk) disable iff (rst) !so_oe |-> !so)
    else $error("data driven while output disabled");
  a_reset_quiet: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |-> !so_oe && !fill_active)
    else $error("outputs active after reset");
  // serial timing: no drive before edge 41, then drive only for the read opcode
  a_oe_start: assert property (@(posedge sck) disable iff (cs_n || rst)
    cnt < 8'h28 |-> !so_oe)
    else $error("output enabled before dummy clocks ended");
  a_oe_opcode: assert property (@(posedge sck) disable iff (cs_n || rst)
    cnt >= 8'h28 |-> so_oe == op_ok)
    else $error("output enable does not follow opcode");
  a_sig_bytes: assert property (@(posedge sck) disable iff (cs_n || rst)
    cnt inside {[8'h28:8'h3F]} && op_ok && head[23:0] == 24'h0 |-> so == sig[8'h3F - cnt])
    else $error("signature bit wrong");
  // fill engine starts only inside a frame and is idle by the fifth clock after deselect
  a_fill_idle: assert property (@(posedge clk) disable iff (rst) cs_n [*5] |-> !fill_active)
    else $error("fill engine busy while deselected");
  a_fill_select: assert property (@(posedge clk) disable iff (rst)
    $rose(fill_active) |-> !cs_n)
    else $error("fill engine started outside a frame");
  c_read_hdr: cover property (@(posedge sck) cnt == 8'h28 && op_ok && head[23:0] == 24'h0);
  c_refused: cover property (@(posedge sck) cnt == 8'h28 && !op_ok);
  c_fill: cover property (@(posedge clk) $rose(fill_active));
endmodule

// file: tb/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic [7:0] got [$];
  logic oe_any;
  logic oe_all;
  // idle bus: clock low, deselected
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // one frame: opcode, address, dummy clocks, then n bytes sampled on rising edges
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int n);
    logic [31:0] w;
    logic [7:0] b;
    w = {op, a};
    b = 8'h00;
    got.delete();
    oe_any = 1'b0;
    oe_all = 1'b1;
    #7 cs_n = 1'b0;
    for (int i = 0; i < 40 + 8 * n; i++) begin
      #20 si = (i < 32) ? w[31 - i] : ~si;
      #20 sck = 1'b1;
      oe_any |= so_oe;
      if (i >= 40) begin
        b = {b[6:0], so_oe ? so : ~b[0]};
        oe_all &= so_oe;
        if (i % 8 == 7) got.push_back(b);
      end
      #40 sck = 1'b0;
    end
    #40 cs_n = 1'b1;
    si = ~si;
    #240;
  endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk;
  logic rst;
  wire sck;
  wire cs_n;
  wire si;
  wire so;
  wire so_oe;
  wire fill_active;
  int error_cnt = 0;
  int comparisons = 0;
  logic [23:0] p_basic;
  logic [23:0] p_fourb;
  logic [7:0] hdr [0:23] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h01, 8'hFF,
    8'h00, 8'h06, 8'h01, 8'h10, 8'h00, 8'h03, 8'h00, 8'hFF,
    8'h84, 8'h00, 8'h01, 8'h02, 8'h40, 8'h03, 8'h00, 8'hFF};
  sfdp_reader #(
    .BASIC_TABLE({16{32'h11223344}}),
    .FOURB_TABLE(64'h0123456789ABCDEF)
  ) u_dut (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .fill_active(fill_active));
  spi_host_model u_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
  // compare one byte and count it
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // read n bytes at a, first expected byte in the top of e
  task automatic rd(input logic [23:0] a, input logic [31:0] e, input int n);
    u_host.frame(8'h5A, a, n);
    for (int i = 0; i < n; i++) check(u_host.got[i], e[31 - 8 * i -: 8]);
    check({7'h00, fill_active}, 8'h00);
  endtask
  task automatic t_header();
    u_host.frame(8'h5A, 24'h000000, 24);
    for (int i = 0; i < 24; i++) check(u_host.got[i], hdr[i]);
    check({7'h00, u_host.oe_all}, 8'h01);
    p_basic = {u_host.got[14], u_host.got[13], u_host.got[12]};
    p_fourb = {u_host.got[22], u_host.got[21], u_host.got[20]};
    $display("done: header");
  endtask
  // gaps, table starts and the seam between the tables
  task automatic t_tables();
    rd(p_basic - 24'h2, 32'hFFFF1122, 4);
    rd(p_fourb - 24'h2, 32'h33440123, 4);
    rd(p_fourb + 24'h6, 32'hCDEFFF00, 3);
    rd(24'hFFFFFF, 32'hFF530000, 2);
    $display("done: tables");
  endtask
  // other opcodes, a program attempt among them, get no answer and change nothing
  task automatic t_refuse();
    logic [7:0] ops [0:3] = '{8'h03, 8'h0B, 8'h02, 8'h9F};
    foreach (ops[i]) begin
      u_host.frame(ops[i], 24'h000000, 2);
      check({7'h00, u_host.oe_any}, 8'h00);
    end
    rd(24'h000000, 32'h53464450, 4);
    $display("done: refuse");
  endtask
  task automatic complete_run();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // reset, then the scenarios
  initial begin
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #2 rst = 1'b0;
    repeat (2) @(posedge clk);
    t_header();
    t_tables();
    t_refuse();
    complete_run();
  end
  // watchdog
  initial begin
    #2000000;
    error_cnt++;
    complete_run();
  end
endmodule
bind sfdp_reader sfdp_reader_properties u_props (.clk(clk), .rst(rst), .sck(sck),
  .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .fill_active(fill_active));
